/* rtl/sdl_stall_detect.sv */
// Stall detection with threshold learning, AXI4-Lite register slave
`timescale 1ns/1ps

module sdl_stall_detect (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire sdl_pkg::sdl_axi_req_t axi_req,
  output      sdl_pkg::sdl_axi_rsp_t axi_rsp,
  input  wire logic [7:0]            torque_metric,
  input  wire logic                  elec_cycle,
  output      logic                  fault_out_n
);

  sdl_pkg::sdl_state_t q;
  sdl_pkg::sdl_state_t d;
  logic                wr_go;
  logic                rd_go;
  logic                start_w;
  logic                clear_w;
  logic                run_stall;
  logic                learn_stall;
  logic                stall_evt;
  logic [11:0]         sum_nx;

  function automatic logic [31:0] reg_read(input logic [7:0] a, input sdl_pkg::sdl_state_t s,
                                           input logic [7:0] tq);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (a)
      sdl_pkg::ADDR_FAULT:  r[sdl_pkg::BIT_FAULT_STALL] = s.stall_flag;
      sdl_pkg::ADDR_DIAG2: begin
        r[sdl_pkg::BIT_DIAG_BLOCKED] = s.blocked;
        r[sdl_pkg::BIT_DIAG_LRN_OK]  = s.learn_ok;
        r[sdl_pkg::BIT_DIAG_LRN_BSY] = (s.learn_st != sdl_pkg::LRN_IDLE);
      end
      sdl_pkg::ADDR_CTRL_FIVE: begin
        r[sdl_pkg::BIT_CTRL_FIVE_REPORT] = s.rep_en;
        r[sdl_pkg::BIT_CTRL_FIVE_DETECT] = s.det_en;
      end
      sdl_pkg::ADDR_THRESH: r[7:0] = s.thresh;
      sdl_pkg::ADDR_TORQUE: r[7:0] = tq;
      default:              r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    return (a == sdl_pkg::ADDR_FAULT) || (a == sdl_pkg::ADDR_DIAG2) ||
           (a == sdl_pkg::ADDR_CTRL_FOUR) || (a == sdl_pkg::ADDR_CTRL_FIVE) ||
           (a == sdl_pkg::ADDR_THRESH) || (a == sdl_pkg::ADDR_TORQUE);
  endfunction

  // Write channels are taken together, one response outstanding at most
  assign axi_rsp.awready = axi_req.wvalid & ~q.bvalid;
  assign axi_rsp.wready  = axi_req.awvalid & ~q.bvalid;
  assign axi_rsp.bvalid  = q.bvalid;
  assign axi_rsp.bresp   = q.bresp;
  assign axi_rsp.arready = ~q.rvalid;
  assign axi_rsp.rvalid  = q.rvalid;
  assign axi_rsp.rdata   = q.rdata;
  assign axi_rsp.rresp   = q.rresp;
  assign fault_out_n     = q.fault_n;

  assign wr_go   = axi_req.awvalid & axi_req.wvalid & ~q.bvalid;
  assign rd_go   = axi_req.arvalid & ~q.rvalid;
  assign start_w = wr_go & axi_req.wstrb[0] & (axi_req.awaddr == sdl_pkg::ADDR_CTRL_FIVE) &
                   axi_req.wdata[sdl_pkg::BIT_CTRL_FIVE_LEARN];
  assign clear_w = wr_go & axi_req.wstrb[0] & (axi_req.awaddr == sdl_pkg::ADDR_CTRL_FOUR) &
                   axi_req.wdata[sdl_pkg::BIT_CTRL_FOUR_CLEAR];
  assign sum_nx  = q.sum + {4'h0, torque_metric};

  // Stall seen against the programmed threshold, or against the learned candidate
  assign run_stall   = q.det_en & (torque_metric < q.thresh);
  assign learn_stall = (q.learn_st == sdl_pkg::LRN_WAIT) & q.cand_valid &
                       (torque_metric < q.cand);
  assign stall_evt   = run_stall | learn_stall;

  always_comb begin
    d = q;
    if (q.bvalid && axi_req.bready) begin
      d.bvalid = 1'b0;
    end
    if (q.rvalid && axi_req.rready) begin
      d.rvalid = 1'b0;
    end
    if (rd_go) begin
      d.rvalid = 1'b1;
      d.rdata  = reg_read(axi_req.araddr, q, torque_metric);
      d.rresp  = addr_ok(axi_req.araddr) ? sdl_pkg::RESP_OKAY : sdl_pkg::RESP_SLVERR;
    end
    if (wr_go) begin
      d.bvalid = 1'b1;
      d.bresp  = addr_ok(axi_req.awaddr) ? sdl_pkg::RESP_OKAY : sdl_pkg::RESP_SLVERR;
      if (axi_req.wstrb[0] && axi_req.awaddr == sdl_pkg::ADDR_CTRL_FIVE) begin
        d.rep_en = axi_req.wdata[sdl_pkg::BIT_CTRL_FIVE_REPORT];
        d.det_en = axi_req.wdata[sdl_pkg::BIT_CTRL_FIVE_DETECT];
      end
      if (axi_req.wstrb[0] && axi_req.awaddr == sdl_pkg::ADDR_THRESH) begin
        d.thresh = axi_req.wdata[7:0];
      end
    end
    // Learning sequence
    unique case (q.learn_st)
      sdl_pkg::LRN_IDLE: ;
      sdl_pkg::LRN_RUN: begin
        if (elec_cycle) begin
          d.sum     = sum_nx;
          d.cyc_cnt = q.cyc_cnt + 5'h01;
          if (q.cyc_cnt == sdl_pkg::LEARN_LAST) begin
            d.learn_st   = sdl_pkg::LRN_WAIT;
            d.cand       = {1'b0, sum_nx[11:5]};
            d.cand_valid = (sum_nx[11:4] >= sdl_pkg::MIN_VALID_AVG);
          end
        end
      end
      sdl_pkg::LRN_WAIT: begin
        if (learn_stall) begin
          d.learn_ok = 1'b1;
          d.thresh   = q.cand;
          d.learn_st = sdl_pkg::LRN_IDLE;
        end
      end
      default: d.learn_st = sdl_pkg::LRN_IDLE;
    endcase
    if (start_w) begin
      d.learn_st   = sdl_pkg::LRN_RUN;
      d.cyc_cnt    = 5'h00;
      d.sum        = 12'h000;
      d.cand_valid = 1'b0;
      d.learn_ok   = 1'b0;
    end
    // Clear first, then set, so a stall in the clearing cycle is kept
    if (clear_w && !stall_evt) begin
      d.stall_flag = 1'b0;
      d.blocked    = 1'b0;
    end
    if (stall_evt) begin
      d.stall_flag = 1'b1;
      d.blocked    = 1'b1;
    end
    d.fault_n = ~(d.stall_flag & d.rep_en);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= sdl_pkg::ST_RESET;
    end else begin
      q <= d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  AST_LEARN_START: assert property (start_w |=> q.learn_st == sdl_pkg::LRN_RUN)
    else $error("Learn start did not begin learning");

  AST_LEARN_LEN: assert property (
    q.learn_st == sdl_pkg::LRN_RUN && elec_cycle && !start_w |=>
    (q.learn_st == sdl_pkg::LRN_WAIT) == ($past(q.cyc_cnt) == sdl_pkg::LEARN_LAST))
    else $error("Learning phase length wrong");

  AST_LEARN_STALL: assert property (learn_stall && !start_w && !clear_w |=>
    q.learn_ok && q.blocked && q.stall_flag && (fault_out_n == !q.rep_en))
    else $error("Stall during learning not reported");

  AST_FAULT_PIN: assert property (q.stall_flag && q.rep_en |=>
    !fault_out_n || !q.stall_flag || !q.rep_en)
    else $error("Fault output not low on reported stall");

  AST_STALL_SET: assert property (run_stall |=> q.stall_flag && q.blocked)
    else $error("Detected stall did not set flags");

  AST_CLEAR: assert property (clear_w && !stall_evt |=>
    !q.stall_flag && fault_out_n)
    else $error("Clear did not clear stall fault");

  AST_NO_VALID: assert property (
    q.learn_st == sdl_pkg::LRN_WAIT && !q.cand_valid && !start_w |=>
    !q.learn_ok && q.learn_st == sdl_pkg::LRN_WAIT)
    else $error("Learn complete set without a valid threshold");

  AST_LATCH: assert property (q.stall_flag && !clear_w |=> q.stall_flag[*2] or
    (q.stall_flag ##1 $past(clear_w)))
    else $error("Stall flag dropped without a clear");

  AST_START_RESET: assert property (
    start_w |=> !q.learn_ok && q.cyc_cnt == 5'h00)
    else $error("Learn start did not restart the count");

  AST_RUN_NOT_DONE: assert property (
    q.learn_st == sdl_pkg::LRN_RUN |-> !q.learn_ok)
    else $error("Learn complete set while still learning");

  AST_WAIT_HOLD: assert property (
    q.learn_st == sdl_pkg::LRN_WAIT && !learn_stall && !start_w |=> q.learn_st == sdl_pkg::LRN_WAIT)
    else $error("Learning left the wait without a stall");

  AST_THRESH_LOAD: assert property (
    learn_stall |=> q.thresh == $past(q.cand))
    else $error("Learned threshold not loaded on stall");

  AST_REPORT_OFF: assert property (
    !q.rep_en |-> fault_out_n)
    else $error("Fault output low with reporting off");

  AST_STALL_BLOCKED: assert property (
    $rose(q.stall_flag) |-> q.blocked)
    else $error("Stall flag set without the blocked bit");

  AST_BLOCK_LATCH: assert property (
    q.blocked && !clear_w |=> q.blocked)
    else $error("Blocked bit dropped without a clear");

  AST_PIN_LATCH: assert property (
    !fault_out_n && !wr_go |=> !fault_out_n)
    else $error("Fault output released without a write");

endmodule

/* rtl/sdl_pkg.sv */
// Package for the stall detection and threshold learning block
package sdl_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_FAULT     = 8'h00;
  localparam logic [7:0] ADDR_DIAG2     = 8'h04;
  localparam logic [7:0] ADDR_CTRL_FOUR = 8'h08;
  localparam logic [7:0] ADDR_CTRL_FIVE = 8'h0C;
  localparam logic [7:0] ADDR_THRESH    = 8'h10;
  localparam logic [7:0] ADDR_TORQUE    = 8'h14;

  // Field positions
  localparam int unsigned BIT_FAULT_STALL      = 0;
  localparam int unsigned BIT_DIAG_BLOCKED     = 0;
  localparam int unsigned BIT_DIAG_LRN_OK      = 1;
  localparam int unsigned BIT_DIAG_LRN_BSY     = 2;
  localparam int unsigned BIT_CTRL_FOUR_CLEAR  = 0;
  localparam int unsigned BIT_CTRL_FIVE_LEARN  = 0;
  localparam int unsigned BIT_CTRL_FIVE_REPORT = 1;
  localparam int unsigned BIT_CTRL_FIVE_DETECT = 2;

  // Learning figures
  localparam logic [4:0] LEARN_CYCLES  = 5'h10;
  localparam logic [4:0] LEARN_LAST    = 5'h0F;
  localparam logic [7:0] MIN_VALID_AVG = 8'h10;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    LRN_IDLE = 2'b00,
    LRN_RUN  = 2'b01,
    LRN_WAIT = 2'b10
  } sdl_learn_t;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } sdl_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } sdl_axi_rsp_t;

  typedef struct packed {
    sdl_learn_t  learn_st;
    logic [4:0]  cyc_cnt;
    logic [11:0] sum;
    logic [7:0]  cand;
    logic        cand_valid;
    logic [7:0]  thresh;
    logic        rep_en;
    logic        det_en;
    logic        stall_flag;
    logic        blocked;
    logic        learn_ok;
    logic        fault_n;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } sdl_state_t;

  localparam sdl_state_t ST_RESET = '{
    learn_st:   LRN_IDLE,
    cyc_cnt:    5'h00,
    sum:        12'h000,
    cand:       8'h00,
    cand_valid: 1'b0,
    thresh:     8'h00,
    rep_en:     1'b1,
    det_en:     1'b0,
    stall_flag: 1'b0,
    blocked:    1'b0,
    learn_ok:   1'b0,
    fault_n:    1'b1,
    bvalid:     1'b0,
    bresp:      2'h0,
    rvalid:     1'b0,
    rdata:      32'h0000_0000,
    rresp:      2'h0
  };

endpackage

/* bench/sdl_motor_model.sv */
// Motor model: electrical cycle pulses and torque count
`timescale 1ns/1ps
module sdl_motor_model (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [7:0] run_tq,
  input  wire logic       stalled,
  output      logic       elec_cycle,
  output      logic [7:0] torque_metric
);
  logic [1:0] div_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= 2'h0;
    end else begin
      div_q <= div_q + 2'h1;
    end
  end
  // Drive keeps pulsing while held; torque count collapses
  assign elec_cycle    = reset_n && (div_q == 2'h3);
  assign torque_metric = stalled ? 8'h04 : run_tq;
endmodule

/* bench/testbench.sv */
// Testbench for the stall detection and learning block
`timescale 1ns/1ps
module testbench;
  logic                  clk = 1'b0;
  logic                  reset_n = 1'b0;
  sdl_pkg::sdl_axi_req_t axi_req = '{bready: 1'b1, rready: 1'b1, default: '0};
  sdl_pkg::sdl_axi_rsp_t axi_rsp;
  logic [7:0]            run_tq = 8'h40;
  logic                  stalled = 1'b0;
  logic                  elec_cycle;
  logic [7:0]            torque_metric;
  logic                  fault_out_n;
  logic [31:0]           rd_q;
  logic [1:0]            resp_q;
  int                    n_fail = 0;
  int                    total_checks = 0;
  always #12.5 clk = ~clk;
  sdl_stall_detect u_dut (.clk(clk), .reset_n(reset_n), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .torque_metric(torque_metric), .elec_cycle(elec_cycle), .fault_out_n(fault_out_n));
  sdl_motor_model u_motor (.clk(clk), .reset_n(reset_n), .run_tq(run_tq), .stalled(stalled),
    .elec_cycle(elec_cycle), .torque_metric(torque_metric));
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    @(posedge clk);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr  <= addr;
    axi_req.wvalid  <= 1'b1;
    axi_req.wdata   <= data;
    axi_req.wstrb   <= 4'hF;
    do @(negedge clk); while (!(axi_rsp.awready && axi_rsp.wready));
    @(posedge clk);
    axi_req.awvalid <= 1'b0;
    axi_req.wvalid  <= 1'b0;
    do @(negedge clk); while (!axi_rsp.bvalid);
    resp_q = axi_rsp.bresp;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] addr);
    @(posedge clk);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr  <= addr;
    do @(negedge clk); while (!axi_rsp.arready);
    @(posedge clk);
    axi_req.arvalid <= 1'b0;
    do @(negedge clk); while (!axi_rsp.rvalid);
    rd_q   = axi_rsp.rdata;
    resp_q = axi_rsp.rresp;
    @(posedge clk);
  endtask
  task automatic t_reset;
    rd(sdl_pkg::ADDR_CTRL_FIVE);
    chk("ctrl five", 32'h0000_0002, rd_q);
    chk("read resp", {30'h0, sdl_pkg::RESP_OKAY}, {30'h0, resp_q});
    rd(sdl_pkg::ADDR_FAULT);
    chk("fault reg", 32'h0000_0000, rd_q);
    rd(8'h18);
    chk("unmapped resp", {30'h0, sdl_pkg::RESP_SLVERR}, {30'h0, resp_q});
    chk("unmapped data", 32'h0000_0000, rd_q);
    wr(8'h18, 32'h0000_00FF);
    chk("unmapped wr resp", {30'h0, sdl_pkg::RESP_SLVERR}, {30'h0, resp_q});
    wr(sdl_pkg::ADDR_THRESH, 32'h0000_0000);
    chk("write resp", {30'h0, sdl_pkg::RESP_OKAY}, {30'h0, resp_q});
    chk("fault pin", 32'h1, {31'h0, fault_out_n});
  endtask
  task automatic t_learn;
    rd(sdl_pkg::ADDR_TORQUE);
    chk("torque", 32'h0000_0040, rd_q);
    wr(sdl_pkg::ADDR_CTRL_FIVE, 32'h0000_0003);
    rd(sdl_pkg::ADDR_DIAG2);
    chk("busy", 32'h1, {31'h0, rd_q[sdl_pkg::BIT_DIAG_LRN_BSY]});
    repeat (80) @(posedge clk);
    chk("pin waiting", 32'h1, {31'h0, fault_out_n});
    rd(sdl_pkg::ADDR_DIAG2);
    chk("lrn ok early", 32'h0, {31'h0, rd_q[sdl_pkg::BIT_DIAG_LRN_OK]});
    chk("still waiting", 32'h1, {31'h0, rd_q[sdl_pkg::BIT_DIAG_LRN_BSY]});
    stalled <= 1'b1;
    repeat (3) @(posedge clk);
    chk("pin stalled", 32'h0, {31'h0, fault_out_n});
    rd(sdl_pkg::ADDR_DIAG2);
    chk("diag2 learnt", 32'h3, {30'h0, rd_q[1:0]});
    rd(sdl_pkg::ADDR_FAULT);
    chk("stall flag", 32'h1, rd_q);
    rd(sdl_pkg::ADDR_TORQUE);
    chk("torque stalled", 32'h0000_0004, rd_q);
    rd(sdl_pkg::ADDR_THRESH);
    chk("threshold", 32'h0000_0020, rd_q);
    stalled <= 1'b0;
    repeat (3) @(posedge clk);
    chk("pin latched", 32'h0, {31'h0, fault_out_n});
    rd(sdl_pkg::ADDR_FAULT);
    chk("flag latched", 32'h1, rd_q);
    wr(sdl_pkg::ADDR_CTRL_FOUR, 32'h0000_0001);
    rd(sdl_pkg::ADDR_FAULT);
    chk("flag cleared", 32'h0, rd_q);
    chk("pin cleared", 32'h1, {31'h0, fault_out_n});
  endtask
  task automatic t_manual;
    wr(sdl_pkg::ADDR_THRESH, 32'h0000_0030);
    wr(sdl_pkg::ADDR_CTRL_FIVE, 32'h0000_0004);
    stalled <= 1'b1;
    repeat (3) @(posedge clk);
    chk("pin unreported", 32'h1, {31'h0, fault_out_n});
    rd(sdl_pkg::ADDR_FAULT);
    chk("manual flag", 32'h1, rd_q);
    wr(sdl_pkg::ADDR_CTRL_FOUR, 32'h0000_0001);
    rd(sdl_pkg::ADDR_FAULT);
    chk("clear while stalled", 32'h1, rd_q);
    wr(sdl_pkg::ADDR_CTRL_FIVE, 32'h0000_0006);
    chk("pin reported", 32'h0, {31'h0, fault_out_n});
    stalled <= 1'b0;
    wr(sdl_pkg::ADDR_CTRL_FOUR, 32'h0000_0001);
    rd(sdl_pkg::ADDR_DIAG2);
    chk("blocked cleared", 32'h0, {31'h0, rd_q[sdl_pkg::BIT_DIAG_BLOCKED]});
  endtask
  task automatic t_low_speed;
    wr(sdl_pkg::ADDR_CTRL_FIVE, 32'h0000_0002);
    run_tq <= 8'h08;
    repeat (8) @(posedge clk);
    wr(sdl_pkg::ADDR_CTRL_FIVE, 32'h0000_0003);
    repeat (80) @(posedge clk);
    stalled <= 1'b1;
    repeat (3) @(posedge clk);
    rd(sdl_pkg::ADDR_DIAG2);
    chk("low lrn ok", 32'h0, {31'h0, rd_q[sdl_pkg::BIT_DIAG_LRN_OK]});
    stalled <= 1'b0;
    run_tq  <= 8'h40;
    wr(sdl_pkg::ADDR_CTRL_FIVE, 32'h0000_0003);
    repeat (80) @(posedge clk);
    stalled <= 1'b1;
    repeat (3) @(posedge clk);
    rd(sdl_pkg::ADDR_DIAG2);
    chk("relearn ok", 32'h1, {31'h0, rd_q[sdl_pkg::BIT_DIAG_LRN_OK]});
    stalled <= 1'b0;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_learn();
    t_manual();
    t_low_speed();
    end_of_test();
  end
  initial begin
    #(25 * 5000);
    n_fail++;
    end_of_test();
  end
endmodule
